// file: common/bma_pkg.sv
package bma_pkg;

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  localparam int          PC_W         = 13;
  localparam int          PROG_W       = 11;
  localparam logic [12:0] PC_RESET_VEC = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC   = 13'h0004;
  localparam logic [12:0] PC_IMPL_MASK = 13'h07FF;

  // ---------------------------------------------------------------
  // Data memory map (offsets inside a 128-location bank)
  // ---------------------------------------------------------------
  localparam int         DADDR_W        = 9;
  localparam logic [6:0] SPECIAL_LIMIT   = 7'h20;
  localparam logic [6:0] SHARED_BASE     = 7'h70;
  localparam logic [6:0] BANK1_RAM_END   = 7'h3F;
  localparam logic [6:0] RAM_BANK1_SHIFT = 7'h40;
  localparam int         RAM_DEPTH       = 128;
  localparam int         SPECIAL_DEPTH   = 128;

  // ---------------------------------------------------------------
  // Avalon register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_BANK_CTRL = 4'h0;
  localparam logic [3:0] REG_POINTER   = 4'h4;
  localparam logic [3:0] REG_PC        = 4'h8;
  localparam logic [3:0] REG_LAST_ADDR = 4'hC;
  localparam int         BANK_LOW_BIT  = 0;
  localparam int         BANK_HIGH_BIT = 1;
  localparam int         IND_BANK_BIT  = 2;
  localparam logic [2:0] CTRL_RESET    = 3'h0;
  localparam logic [7:0] POINTER_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       indirect;
    logic [6:0] opc_addr;
    logic [7:0] wdata;
  } data_req_type;

  typedef struct packed {
    logic        irq_take;
    logic        load;
    logic        inc;
    logic [12:0] target;
  } pc_ctrl_type;

  typedef struct packed {
    logic       special;
    logic       ram;
    logic [6:0] idx;
  } decode_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_type;

endpackage : bma_pkg

// file: rtl/banked_memory_addressing.sv
`timescale 1ns/1ps
// What this block does
// - Thirteen-bit program counter spans an 8k word program space.
// - Only lowest 2k words exist; higher fetch addresses fold onto them.
// - Reset loads counter with 0000h; interrupt redirects to 0004h.
// - Four data banks; lowest 32 addresses of each hold special registers.
// - Bank zero 20h-7Fh and bank one A0h-BFh are general RAM.
// - Top sixteen addresses of banks one to three alias bank zero 70h-7Fh.
// - Reads of unimplemented data locations return zero.
// - Direct address is seven opcode bits under two bank select bits.
// - Bank select pair high,low chooses banks zero to three in order.
// - Indirect address is pointer low eight bits plus indirect bank bit.
// - Each bank is 128 byte locations, reached directly or indirectly.
// - Special registers are static storage that keep contents unrefreshed.
module banked_memory_addressing
  import bma_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire pc_ctrl_type       pc_ctrl_in,
  output logic [PROG_W-1:0]      fetch_addr_out,
  output logic [PC_W-1:0]        pc_out,
  input  wire data_req_type      data_req_in,
  output logic [7:0]             data_rdata_out,
  output logic                   data_rvalid_out,
  input  wire logic [3:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic decode_type decode_addr(input logic [DADDR_W-1:0] a);
    decode_type r;
    logic [1:0] b;
    logic [6:0] o;
    r = '0;
    b = a[8:7];
    o = a[6:0];
    if (o < SPECIAL_LIMIT) begin
      r.special = 1'b1;
      r.idx     = {b, o[4:0]};
    end else if (b == 2'b00) begin
      r.ram = 1'b1;
      r.idx = 7'(o - SPECIAL_LIMIT);
    end else if (o >= SHARED_BASE) begin
      r.ram = 1'b1;
      r.idx = 7'(o - SPECIAL_LIMIT);
    end else if (b == 2'b01 && o <= BANK1_RAM_END) begin
      r.ram = 1'b1;
      r.idx = 7'(o + RAM_BANK1_SHIFT);
    end
    return r;
  endfunction : decode_addr

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [2:0]         bank_ctrl_q;
  logic [7:0]         indirect_pointer_q;
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    pc_d;
  logic [DADDR_W-1:0] last_addr_q;
  logic [7:0]         rdata_q;
  logic               rvalid_q;
  logic [31:0]        avs_rdata_q;
  bus_state_type      bus_state_q;

  wire logic bank_select_low  = bank_ctrl_q[BANK_LOW_BIT];
  wire logic bank_select_high = bank_ctrl_q[BANK_HIGH_BIT];
  wire logic indirect_bank_bit = bank_ctrl_q[IND_BANK_BIT];

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    if (pc_ctrl_in.irq_take) begin
      pc_d = PC_IRQ_VEC;
    end else if (pc_ctrl_in.load) begin
      pc_d = pc_ctrl_in.target;
    end else if (pc_ctrl_in.inc) begin
      pc_d = PC_W'(pc_q + 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_q <= PC_RESET_VEC;
    end else begin
      pc_q <= pc_d;
    end
  end

  assign pc_out         = pc_q;
  assign fetch_addr_out = pc_q[PROG_W-1:0];

  // ---------------------------------------------------------------
  // Data address formation
  // ---------------------------------------------------------------
  wire logic [DADDR_W-1:0] direct_addr   = {bank_select_high, bank_select_low, data_req_in.opc_addr};
  wire logic [DADDR_W-1:0] indirect_addr = {indirect_bank_bit, indirect_pointer_q};
  wire logic [DADDR_W-1:0] cur_addr      = data_req_in.indirect ? indirect_addr : direct_addr;
  wire decode_type         cur_dec       = decode_addr(cur_addr);
  wire logic               special_we    = data_req_in.wr && cur_dec.special;
  wire logic               ram_we        = data_req_in.wr && cur_dec.ram;
  wire logic               unimpl        = !cur_dec.special && !cur_dec.ram;

  // ---------------------------------------------------------------
  // Storage (static, no reset, no refresh)
  // ---------------------------------------------------------------
  logic [7:0] ram_mem     [RAM_DEPTH];
  logic [7:0] special_mem [SPECIAL_DEPTH];

  always_ff @(posedge clk_in) begin
    if (ram_we) begin
      ram_mem[cur_dec.idx] <= data_req_in.wdata;
    end
    if (special_we) begin
      special_mem[cur_dec.idx] <= data_req_in.wdata;
    end
  end

  wire logic [7:0] read_value = cur_dec.ram     ? ram_mem[cur_dec.idx] :
                                cur_dec.special ? special_mem[cur_dec.idx] : 8'h00;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q     <= 8'h00;
      rvalid_q    <= 1'b0;
      last_addr_q <= '0;
    end else begin
      rvalid_q <= data_req_in.rd;
      if (data_req_in.rd) begin
        rdata_q <= read_value;
      end
      if (data_req_in.rd || data_req_in.wr) begin
        last_addr_q <= cur_addr;
      end
    end
  end

  assign data_rdata_out  = rdata_q;
  assign data_rvalid_out = rvalid_q;

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  wire logic        avs_req     = avs_read_in || avs_write_in;
  wire logic        avs_take    = avs_req && (bus_state_q == BUS_IDLE);
  wire logic        wr_ctrl     = avs_take && avs_write_in && avs_byteenable_in[0]
                                  && (avs_address_in == REG_BANK_CTRL);
  wire logic        wr_pointer  = avs_take && avs_write_in && avs_byteenable_in[0]
                                  && (avs_address_in == REG_POINTER);
  wire logic [31:0] avs_rd_mux  = (avs_address_in == REG_BANK_CTRL) ? {29'h0, bank_ctrl_q} :
                                  (avs_address_in == REG_POINTER)   ? {24'h0, indirect_pointer_q} :
                                  (avs_address_in == REG_PC)        ? {19'h0, pc_q} :
                                  (avs_address_in == REG_LAST_ADDR) ? {23'h0, last_addr_q} :
                                  32'h0000_0000;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bank_ctrl_q        <= CTRL_RESET;
      indirect_pointer_q <= POINTER_RESET;
      avs_rdata_q        <= 32'h0000_0000;
      bus_state_q        <= BUS_IDLE;
    end else begin
      case (bus_state_q)
        BUS_IDLE: begin
          if (avs_req) begin
            bus_state_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_state_q <= BUS_IDLE;
        end
        default: begin
          bus_state_q <= BUS_IDLE;
        end
      endcase
      if (wr_ctrl) begin
        bank_ctrl_q <= avs_writedata_in[2:0];
      end
      if (wr_pointer) begin
        indirect_pointer_q <= avs_writedata_in[7:0];
      end
      if (avs_take && avs_read_in) begin
        avs_rdata_q <= avs_rd_mux;
      end
    end
  end

  assign avs_waitrequest_out = avs_req && (bus_state_q != BUS_ACK);
  assign avs_readdata_out    = avs_rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_pc_increment;
    pc_ctrl_in.inc && !pc_ctrl_in.load && !pc_ctrl_in.irq_take
      |=> pc_q == PC_W'($past(pc_q) + 1'b1);
  endproperty
  a_pc_increment: assert property (p_pc_increment) else $error("pc did not step by one");

  property p_pc_load;
    pc_ctrl_in.load && !pc_ctrl_in.irq_take |=> pc_q == $past(pc_ctrl_in.target);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc did not load target");

  property p_fetch_fold;
    pc_q[12:11] != 2'b00 |-> fetch_addr_out == PROG_W'(pc_q & PC_IMPL_MASK);
  endproperty
  a_fetch_fold: assert property (p_fetch_fold) else $error("fetch address not folded");

  property p_irq_vector;
    pc_ctrl_in.irq_take |=> pc_q == PC_IRQ_VEC && fetch_addr_out == PC_IRQ_VEC[PROG_W-1:0];
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("interrupt vector not taken");

  property p_special_region;
    cur_addr[6:0] < SPECIAL_LIMIT |-> cur_dec.special && !cur_dec.ram;
  endproperty
  a_special_region: assert property (p_special_region) else $error("low bank addresses not special");

  property p_bank0_ram;
    cur_addr[8:7] == 2'b00 && cur_addr[6:0] >= SPECIAL_LIMIT
      |-> cur_dec.ram && cur_dec.idx == 7'(cur_addr[6:0] - SPECIAL_LIMIT);
  endproperty
  a_bank0_ram: assert property (p_bank0_ram) else $error("bank zero ram misplaced");

  property p_bank1_ram;
    cur_addr[8:7] == 2'b01 && cur_addr[6:0] >= SPECIAL_LIMIT && cur_addr[6:0] <= BANK1_RAM_END
      |-> cur_dec.ram && cur_dec.idx == 7'(cur_addr[6:0] + RAM_BANK1_SHIFT);
  endproperty
  a_bank1_ram: assert property (p_bank1_ram) else $error("bank one ram misplaced");

  // Same offset seen through bank zero
  wire decode_type bank0_dec = decode_addr({2'b00, cur_addr[6:0]});

  property p_shared_alias;
    cur_addr[6:0] >= SHARED_BASE |-> cur_dec.ram && cur_dec.idx == bank0_dec.idx;
  endproperty
  a_shared_alias: assert property (p_shared_alias) else $error("shared window not aliased");

  property p_upper_unimpl;
    cur_addr[8] && cur_addr[6:0] >= SPECIAL_LIMIT && cur_addr[6:0] < SHARED_BASE |-> unimpl;
  endproperty
  a_upper_unimpl: assert property (p_upper_unimpl) else $error("bank two or three gap implemented");

  property p_bank1_gap;
    cur_addr[8:7] == 2'b01 && cur_addr[6:0] > BANK1_RAM_END && cur_addr[6:0] < SHARED_BASE |-> unimpl;
  endproperty
  a_bank1_gap: assert property (p_bank1_gap) else $error("bank one gap implemented");

  property p_unimpl_mux;
    unimpl |-> read_value == 8'h00;
  endproperty
  a_unimpl_mux: assert property (p_unimpl_mux) else $error("unimplemented location not zero");

  sequence s_unimpl_read;
    data_req_in.rd && unimpl;
  endsequence
  sequence s_zero_answer;
    rvalid_q && rdata_q == 8'h00;
  endsequence
  property p_unimpl_zero;
    s_unimpl_read |=> s_zero_answer;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero");

  property p_direct_addr;
    !data_req_in.indirect |-> cur_addr[6:0] == data_req_in.opc_addr
      && cur_addr[8:7] == {bank_ctrl_q[BANK_HIGH_BIT], bank_ctrl_q[BANK_LOW_BIT]};
  endproperty
  a_direct_addr: assert property (p_direct_addr) else $error("direct address wrong");

  property p_bank_choice;
    wr_ctrl ##1 !data_req_in.indirect |-> cur_addr[8:7] == $past(avs_writedata_in[1:0]);
  endproperty
  a_bank_choice: assert property (p_bank_choice) else $error("bank select not honoured");

  property p_indirect_addr;
    data_req_in.indirect |-> cur_addr == {bank_ctrl_q[IND_BANK_BIT], indirect_pointer_q};
  endproperty
  a_indirect_addr: assert property (p_indirect_addr) else $error("indirect address wrong");

  property p_unimpl_write;
    data_req_in.wr && unimpl |-> !ram_we && !special_we;
  endproperty
  a_unimpl_write: assert property (p_unimpl_write) else $error("write to unimplemented stored");

  property p_ram_write_lands;
    ram_we |=> ram_mem[$past(cur_dec.idx)] == $past(data_req_in.wdata);
  endproperty
  a_ram_write_lands: assert property (p_ram_write_lands) else $error("ram write lost");

  property p_special_write_lands;
    special_we |=> special_mem[$past(cur_dec.idx)] == $past(data_req_in.wdata);
  endproperty
  a_special_write_lands: assert property (p_special_write_lands) else $error("special write lost");

  property p_bus_answer;
    avs_req && bus_state_q == BUS_IDLE |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one wait");

endmodule : banked_memory_addressing

// file: sim/core_model.sv
`timescale 1ns/1ps
module core_model
  import bma_pkg::*;
(
  input  wire logic       clk_in,
  output pc_ctrl_type     pc_ctrl_out,
  output data_req_type    data_req_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in
);
  initial begin
    pc_ctrl_out  = '0;
    data_req_out = '0;
  end

  // Counter step; released target shows inverted value
  task automatic pc_step(input logic irq, ld, inc, input logic [12:0] t);
    @(posedge clk_in);
    pc_ctrl_out <= '{irq, ld, inc, t};
    @(posedge clk_in);
    pc_ctrl_out <= '{1'b0, 1'b0, 1'b0, ~t};
    @(posedge clk_in);
  endtask : pc_step

  // One data access; answer sampled the cycle after
  task automatic op(input logic rd, wr, ind, input logic [6:0] a, input logic [7:0] d,
                    output logic [7:0] q, output logic ok);
    @(posedge clk_in);
    data_req_out <= '{rd, wr, ind, a, d};
    @(posedge clk_in);
    data_req_out <= '{1'b0, 1'b0, ~ind, ~a, ~d};
    @(posedge clk_in);
    q  = rdata_in;
    ok = rvalid_in;
  endtask : op
endmodule : core_model

// file: sim/banked_memory_addressing_bench.sv
`timescale 1ns/1ps
module banked_memory_addressing_bench
  import bma_pkg::*;
;
  logic         clk_in;
  logic         arst_n_in;
  pc_ctrl_type  pc_ctrl;
  data_req_type data_req;
  logic [10:0]  fetch_addr;
  logic [12:0]  pc;
  logic [7:0]   rdata;
  logic         rvalid;
  logic [3:0]   avs_address;
  logic         avs_read;
  logic         avs_write;
  logic [31:0]  avs_writedata;
  logic [3:0]   avs_byteenable;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [31:0]  q32;
  logic [7:0]   q8;
  logic         v;
  int           fail_count = 0;
  int           comparisons = 0;
  int           cycles = 0;

  banked_memory_addressing banked_memory_addressing_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .pc_ctrl_in(pc_ctrl),
    .fetch_addr_out(fetch_addr), .pc_out(pc), .data_req_in(data_req),
    .data_rdata_out(rdata), .data_rvalid_out(rvalid),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest));

  core_model core_model_i (
    .clk_in(clk_in), .pc_ctrl_out(pc_ctrl), .data_req_out(data_req),
    .rdata_in(rdata), .rvalid_in(rvalid));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_word(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word

  task automatic chk_data(input logic [7:0] got, exp, input string m);
    comparisons++;
    if (v !== 1'b1 || got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_data

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_in);
    avs_read       <= !w;
    avs_write      <= w;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
    q32 = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  task automatic ctl(input logic [2:0] c);
    av(1'b1, REG_BANK_CTRL, {29'h0, c}, 4'h1);
  endtask : ctl

  task automatic dwr(input logic ind, input logic [6:0] a, input logic [7:0] d);
    core_model_i.op(1'b0, 1'b1, ind, a, d, q8, v);
  endtask : dwr

  task automatic drd(input logic ind, input logic [6:0] a, input logic [7:0] e);
    core_model_i.op(1'b1, 1'b0, ind, a, 8'h00, q8, v);
    chk_data(q8, e, "data read");
  endtask : drd

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------
  // Tests
  // ----------------
  initial begin
    arst_n_in      = 1'b0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 4'h0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    chk_word(32'(pc), 32'h0000_0000, "pc reset");
    av(1'b0, REG_BANK_CTRL, 32'h0000_0000, 4'h0);
    chk_word(q32, 32'h0000_0000, "ctrl reset");
    $display("test reset done");
    core_model_i.pc_step(1'b0, 1'b1, 1'b0, 13'h07FF);
    core_model_i.pc_step(1'b0, 1'b0, 1'b1, 13'h0000);
    chk_word(32'(pc), 32'h0000_0800, "pc above 2k");
    chk_word(32'(fetch_addr), 32'h0000_0000, "fetch fold");
    core_model_i.pc_step(1'b0, 1'b1, 1'b1, 13'h1FFF);
    chk_word(32'(fetch_addr), 32'h0000_07FF, "fetch top");
    core_model_i.pc_step(1'b0, 1'b0, 1'b1, 13'h0000);
    chk_word(32'(pc), 32'h0000_0000, "pc wrap");
    core_model_i.pc_step(1'b1, 1'b1, 1'b1, 13'h1234);
    chk_word(32'(pc), 32'h0000_0004, "irq vector");
    av(1'b0, REG_PC, 32'h0000_0000, 4'h0);
    chk_word(q32, 32'h0000_0004, "pc register");
    $display("test pc done");
    ctl(3'h0);
    dwr(1'b0, 7'h20, 8'hA1);
    dwr(1'b0, 7'h40, 8'hA2);
    ctl(3'h1);
    dwr(1'b0, 7'h20, 8'hB1);
    dwr(1'b0, 7'h3F, 8'hB2);
    dwr(1'b0, 7'h40, 8'hEE);
    drd(1'b0, 7'h40, 8'h00);
    drd(1'b0, 7'h20, 8'hB1);
    ctl(3'h2);
    dwr(1'b0, 7'h20, 8'hCC);
    drd(1'b0, 7'h20, 8'h00);
    ctl(3'h3);
    dwr(1'b0, 7'h75, 8'h5A);
    for (int b = 0; b < 4; b++) begin
      ctl(3'(b));
      dwr(1'b0, 7'h05, 8'h10 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      ctl(3'(b));
      drd(1'b0, 7'h05, 8'h10 + 8'(b));
      drd(1'b0, 7'h75, 8'h5A);
    end
    ctl(3'h0);
    drd(1'b0, 7'h20, 8'hA1);
    drd(1'b0, 7'h40, 8'hA2);
    core_model_i.op(1'b1, 1'b1, 1'b0, 7'h20, 8'h77, q8, v);
    chk_data(q8, 8'hA1, "read during write");
    drd(1'b0, 7'h20, 8'h77);
    $display("test map done");
    av(1'b1, REG_POINTER, 32'h0000_00A0, 4'h1);
    drd(1'b1, 7'h7F, 8'hB1);
    ctl(3'h4);
    av(1'b1, REG_POINTER, 32'h0000_00F5, 4'h1);
    drd(1'b1, 7'h00, 8'h5A);
    av(1'b1, REG_POINTER, 32'h0000_0005, 4'h1);
    drd(1'b1, 7'h00, 8'h12);
    av(1'b0, REG_LAST_ADDR, 32'h0000_0000, 4'h0);
    chk_word(q32, 32'h0000_0105, "last address");
    $display("test indirect done");
    ctl(3'h3);
    av(1'b1, REG_BANK_CTRL, 32'h0000_0000, 4'h0);
    av(1'b0, REG_BANK_CTRL, 32'h0000_0000, 4'h0);
    chk_word(q32, 32'h0000_0003, "byteenable off");
    av(1'b1, REG_PC, 32'h0000_0100, 4'h1);
    av(1'b0, REG_PC, 32'h0000_0000, 4'h0);
    chk_word(q32, 32'h0000_0004, "pc read only");
    av(1'b0, 4'h2, 32'h0000_0000, 4'h0);
    chk_word(q32, 32'h0000_0000, "unmapped read");
    $display("test bus done");
    report_and_stop();
  end
endmodule : banked_memory_addressing_bench
